// ===== rtl/rect_seq_pkg.sv
package rect_seq_pkg;

    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int VOLT_W = 10;
    localparam int TMR_W = 32;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned SEQ_DELAY_MS = 50;
    localparam int unsigned SLOPE_INTERVAL_US = 1000;

    // ------------------------------------------------------------
    // Bus voltage thresholds, in volts
    // ------------------------------------------------------------
    localparam logic [VOLT_W-1:0] V_DOUBLER = 10'h0C8;
    localparam logic [VOLT_W-1:0] V_BYPASS = 10'h0EB;
    localparam logic [VOLT_W-1:0] V_GOOD_OFF = 10'h0D2;
    localparam logic [VOLT_W-1:0] V_DISABLE = 10'h0BE;
    localparam logic [VOLT_W-1:0] V_OVERVOLT = 10'h190;
    localparam logic [VOLT_W-1:0] V_FAULT = 10'h0B4;
    localparam logic [VOLT_W-1:0] V_PRESENT = 10'h014;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_STEP = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_VOLTS = 8'h08;
    localparam logic [VOLT_W-1:0] STEP_RESET = 10'h005;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_DOUBLER = 4;
    localparam int ST_BYPASS = 5;
    localparam int ST_CONV_EN = 6;
    localparam int ST_GOOD_N = 7;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_CHARGE, S_DOUBLING, S_BYP_WAIT, S_EN_WAIT, S_RUN, S_OVERVOLT
    } seq_state_t;

    typedef struct packed {
        seq_state_t state;
        logic [TMR_W-1:0] timer;
        logic [VOLT_W-1:0] volts;
        logic [VOLT_W-1:0] step;
        logic doubler;
        logic bypass;
        logic conv_en;
        logic good_n;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } seq_regs_t;

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic [VOLT_W-1:0] prev;
        logic flat;
    } slope_regs_t;

endpackage

// ===== rtl/slope_detect.sv
`timescale 1ns/1ps
`default_nettype none

module slope_detect
#(
    parameter int unsigned SAMPLE_CYC = 125000
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [rect_seq_pkg::VOLT_W-1:0] volts,
    input wire logic [rect_seq_pkg::VOLT_W-1:0] step,
    output logic flat
);

    if (SAMPLE_CYC < 2)
    begin : g_bad_sample
        $error("slope_detect: SAMPLE_CYC must be at least 2");
    end

    rect_seq_pkg::slope_regs_t s_q;
    rect_seq_pkg::slope_regs_t s_d;

    function automatic logic [rect_seq_pkg::VOLT_W-1:0] abs_diff(
        input logic [rect_seq_pkg::VOLT_W-1:0] a,
        input logic [rect_seq_pkg::VOLT_W-1:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction

    // ------------------------------------------------------------
    // Compare one sample per interval with the one before
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.flat = 1'b0;
        if (s_q.cnt == rect_seq_pkg::TMR_W'(SAMPLE_CYC - 1))
        begin
            s_d.cnt = '0;
            s_d.prev = volts;
            s_d.flat = abs_diff(volts, s_q.prev) < step;
        end
        else
        begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign flat = s_q.flat;

endmodule // slope_detect

`default_nettype wire

// ===== rtl/rect_seq.sv
`timescale 1ns/1ps
`default_nettype none

module rect_seq
#(
    parameter int unsigned CLK_HZ = rect_seq_pkg::CLK_HZ,
    parameter int unsigned DELAY_CYC =
        CLK_HZ / 1000 * rect_seq_pkg::SEQ_DELAY_MS,
    parameter int unsigned SAMPLE_CYC =
        CLK_HZ / 1000000 * rect_seq_pkg::SLOPE_INTERVAL_US
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [rect_seq_pkg::VOLT_W-1:0] bus_volts,
    input wire logic bus_volts_valid,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic doubler_on,
    output logic bypass_on,
    output logic conv_en,
    output logic bus_good_flag_n
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (DELAY_CYC < 2 || SAMPLE_CYC < 2)
    begin : g_bad_param
        $error("rect_seq: DELAY_CYC and SAMPLE_CYC must be at least 2");
    end

    localparam logic [rect_seq_pkg::TMR_W-1:0] DELAY_LAST =
        rect_seq_pkg::TMR_W'(DELAY_CYC - 1);

    rect_seq_pkg::seq_regs_t st_q;
    rect_seq_pkg::seq_regs_t st_d;
    logic flat;

    // ------------------------------------------------------------
    // Slope detector
    // ------------------------------------------------------------
    slope_detect #(
        .SAMPLE_CYC(SAMPLE_CYC)
    ) u_slope (
        .pclk(pclk),
        .presetn(presetn),
        .volts(st_q.volts),
        .step(st_q.step),
        .flat(flat)
    );

    function automatic logic [31:0] status_word(
        input rect_seq_pkg::seq_regs_t s);
        status_word = '0;
        status_word[rect_seq_pkg::ST_STATE_LSB +: 3] = s.state;
        status_word[rect_seq_pkg::ST_DOUBLER] = s.doubler;
        status_word[rect_seq_pkg::ST_BYPASS] = s.bypass;
        status_word[rect_seq_pkg::ST_CONV_EN] = s.conv_en;
        status_word[rect_seq_pkg::ST_GOOD_N] = s.good_n;
    endfunction

    // ------------------------------------------------------------
    // Sequencer and register slave
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        if (bus_volts_valid)
        begin
            st_d.volts = bus_volts;
        end

        case (st_q.state)
            rect_seq_pkg::S_CHARGE:
            begin
                // Inrush limited charge, everything held off
                st_d.doubler = 1'b0;
                st_d.bypass = 1'b0;
                st_d.conv_en = 1'b0;
                st_d.good_n = 1'b1;
                st_d.timer = '0;
                // A flat slope at a dead bus means no line, not a charged bus
                if (flat && st_q.volts > rect_seq_pkg::V_PRESENT)
                begin
                    if (st_q.volts < rect_seq_pkg::V_DOUBLER)
                    begin
                        st_d.doubler = 1'b1;
                        st_d.state = rect_seq_pkg::S_DOUBLING;
                    end
                    else if (st_q.volts > rect_seq_pkg::V_BYPASS)
                    begin
                        st_d.bypass = 1'b1;
                        st_d.state = rect_seq_pkg::S_BYP_WAIT;
                    end
                end
            end
            rect_seq_pkg::S_DOUBLING:
            begin
                if (flat && st_q.volts > rect_seq_pkg::V_BYPASS)
                begin
                    st_d.bypass = 1'b1;
                    st_d.timer = '0;
                    st_d.state = rect_seq_pkg::S_BYP_WAIT;
                end
            end
            rect_seq_pkg::S_BYP_WAIT:
            begin
                if (st_q.volts < rect_seq_pkg::V_FAULT)
                begin
                    st_d.bypass = 1'b0;
                    st_d.state = rect_seq_pkg::S_CHARGE;
                end
                else if (st_q.timer == DELAY_LAST)
                begin
                    st_d.conv_en = 1'b1;
                    st_d.timer = '0;
                    st_d.state = rect_seq_pkg::S_EN_WAIT;
                end
                else
                begin
                    st_d.timer = st_q.timer + 1'b1;
                end
            end
            rect_seq_pkg::S_EN_WAIT:
            begin
                if (st_q.volts < rect_seq_pkg::V_DISABLE)
                begin
                    st_d.conv_en = 1'b0;
                    st_d.bypass = 1'b0;
                    st_d.doubler = 1'b0;
                    st_d.state = rect_seq_pkg::S_CHARGE;
                end
                else if (st_q.timer == DELAY_LAST)
                begin
                    st_d.good_n = 1'b0;
                    st_d.timer = '0;
                    st_d.state = rect_seq_pkg::S_RUN;
                end
                else
                begin
                    st_d.timer = st_q.timer + 1'b1;
                end
            end
            rect_seq_pkg::S_RUN:
            begin
                if (st_q.volts < rect_seq_pkg::V_DISABLE)
                begin
                    // Past the point of no return: the next start is a full one
                    st_d.conv_en = 1'b0;
                    st_d.good_n = 1'b1;
                    st_d.bypass = 1'b0;
                    st_d.doubler = 1'b0;
                    st_d.state = rect_seq_pkg::S_CHARGE;
                end
                else if (st_q.volts < rect_seq_pkg::V_GOOD_OFF)
                begin
                    st_d.good_n = 1'b1;
                end
                else if (st_q.volts > rect_seq_pkg::V_BYPASS)
                begin
                    // Line came back in time: no new sequence, only status
                    st_d.good_n = 1'b0;
                end
            end
            rect_seq_pkg::S_OVERVOLT:
            begin
                // Thermistor stays in circuit until the bus is safe again
                if (st_q.volts < rect_seq_pkg::V_FAULT)
                begin
                    // Bus collapsed while tripped: start over, bypass stays open
                    st_d.state = rect_seq_pkg::S_CHARGE;
                end
                else if (st_q.volts <= rect_seq_pkg::V_OVERVOLT)
                begin
                    st_d.bypass = 1'b1;
                    st_d.timer = '0;
                    st_d.state = rect_seq_pkg::S_BYP_WAIT;
                end
            end
            default:
            begin
                st_d.state = rect_seq_pkg::S_CHARGE;
            end
        endcase

        // Overvoltage overrides every state
        if (st_q.volts > rect_seq_pkg::V_OVERVOLT)
        begin
            st_d.conv_en = 1'b0;
            st_d.bypass = 1'b0;
            st_d.good_n = 1'b1;
            st_d.timer = '0;
            st_d.state = rect_seq_pkg::S_OVERVOLT;
        end

        // APB: answer prepared in setup, write applied at the access edge
        if (psel && !penable)
        begin
            st_d.pready = 1'b1;
            st_d.prdata = '0;
            if (paddr == rect_seq_pkg::REG_STEP)
            begin
                st_d.prdata = 32'(st_q.step);
            end
            else if (paddr == rect_seq_pkg::REG_STATUS)
            begin
                st_d.prdata = status_word(st_q);
                st_d.pslverr = pwrite;
            end
            else if (paddr == rect_seq_pkg::REG_VOLTS)
            begin
                st_d.prdata = 32'(st_q.volts);
                st_d.pslverr = pwrite;
            end
            else
            begin
                st_d.pslverr = 1'b1;
            end
        end
        if (psel && penable && st_q.pready && pwrite
            && paddr == rect_seq_pkg::REG_STEP)
        begin
            st_d.step = pwdata[rect_seq_pkg::VOLT_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= '0;
            st_q.state <= rect_seq_pkg::S_CHARGE;
            st_q.step <= rect_seq_pkg::STEP_RESET;
            st_q.good_n <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign doubler_on = st_q.doubler;
    assign bypass_on = st_q.bypass;
    assign conv_en = st_q.conv_en;
    assign bus_good_flag_n = st_q.good_n;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    charge_all_open_a: assert property (
        st_q.state == rect_seq_pkg::S_CHARGE && $past(st_q.state) == rect_seq_pkg::S_CHARGE
        |-> !doubler_on && !bypass_on)
        else $error("switch closed while charging");

    charge_off_a: assert property (
        st_q.state == rect_seq_pkg::S_CHARGE |-> !conv_en && bus_good_flag_n)
        else $error("converters or bus-good active while charging");

    doubler_low_a: assert property (
        st_q.state == rect_seq_pkg::S_CHARGE && flat
        && st_q.volts > rect_seq_pkg::V_PRESENT && st_q.volts < rect_seq_pkg::V_DOUBLER
        && st_q.volts <= rect_seq_pkg::V_OVERVOLT
        |=> doubler_on && st_q.state == rect_seq_pkg::S_DOUBLING)
        else $error("doubler not engaged on low flat bus");

    bypass_high_a: assert property (
        $rose(bypass_on) && $past(st_q.state) != rect_seq_pkg::S_OVERVOLT
        |-> $past(flat) && $past(st_q.volts) > rect_seq_pkg::V_BYPASS)
        else $error("bypass closed without flat high bus");

    enable_delay_a: assert property (
        $rose(conv_en) |-> $past(st_q.state) == rect_seq_pkg::S_BYP_WAIT
        && $past(st_q.timer) == DELAY_LAST && bypass_on)
        else $error("converter enable not after full delay");

    good_delay_a: assert property (
        $fell(bus_good_flag_n) && $past(st_q.state) == rect_seq_pkg::S_EN_WAIT
        |-> $past(st_q.timer) == DELAY_LAST && conv_en)
        else $error("bus-good not after full delay");

    good_drop_a: assert property (
        st_q.state == rect_seq_pkg::S_RUN && st_q.volts < rect_seq_pkg::V_GOOD_OFF
        |=> bus_good_flag_n)
        else $error("bus-good kept below drop level");

    disable_low_a: assert property (
        conv_en && st_q.volts < rect_seq_pkg::V_DISABLE |=> !conv_en ##1 !conv_en)
        else $error("converters kept enabled below disable level");

    restart_full_a: assert property (
        $fell(conv_en) && st_q.volts <= rect_seq_pkg::V_OVERVOLT
        |-> st_q.state == rect_seq_pkg::S_CHARGE && !bypass_on && !doubler_on)
        else $error("sequence not restarted after disable");

    ride_through_a: assert property (
        st_q.state == rect_seq_pkg::S_RUN && st_q.volts >= rect_seq_pkg::V_DISABLE
        && st_q.volts <= rect_seq_pkg::V_OVERVOLT |=> st_q.state == rect_seq_pkg::S_RUN)
        else $error("run state left above disable level");

    overvolt_off_a: assert property (
        st_q.volts > rect_seq_pkg::V_OVERVOLT |=> !conv_en && !bypass_on)
        else $error("overvoltage did not disable");

    fault_open_a: assert property (
        bypass_on && st_q.volts < rect_seq_pkg::V_FAULT |=> !bypass_on)
        else $error("bypass kept closed below fault level");

    doubler_path_c: cover property (
        $rose(doubler_on) ##[1:1000] $rose(bypass_on));

    good_seen_c: cover property ($fell(bus_good_flag_n));

    ride_c: cover property (
        st_q.state == rect_seq_pkg::S_RUN && $rose(bus_good_flag_n)
        ##[1:1000] $fell(bus_good_flag_n));

    overvolt_c: cover property ($rose(st_q.state == rect_seq_pkg::S_OVERVOLT));

endmodule // rect_seq

`default_nettype wire

// ===== tb/bus_sense_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bus voltage sensing model
// ----------------------------------------
module bus_sense_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [rect_seq_pkg::VOLT_W-1:0] target,
    input wire logic ramp,
    output logic [rect_seq_pkg::VOLT_W-1:0] volts,
    output logic valid
);
    // Slow converter: one sample every other cycle; ramp moves 1 V a cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            volts <= '0;
            valid <= 1'b0;
        end
        else
        begin
            valid <= ~valid;
            if (!ramp)
                volts <= target;
            else if (volts < target)
                volts <= volts + 10'h001;
            else if (volts > target)
                volts <= volts - 10'h001;
        end
    end
endmodule // bus_sense_model
`default_nettype wire

// ===== tb/tb_autoranging_rectifier_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_autoranging_rectifier_sequencer;
    localparam int DLY = 20;
    logic pclk, presetn, psel, penable, pwrite, ramp, pready, pslverr, valid, err;
    logic doubler_on, bypass_on, conv_en, bus_good_flag_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0] target, volts, v;
    int num_errors, total_checks, n;

    rect_seq #(.DELAY_CYC(DLY), .SAMPLE_CYC(8)) dut (.pclk(pclk), .presetn(presetn),
        .bus_volts(volts), .bus_volts_valid(valid), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .doubler_on(doubler_on),
        .bypass_on(bypass_on), .conv_en(conv_en), .bus_good_flag_n(bus_good_flag_n));
    bus_sense_model sense (.pclk(pclk), .presetn(presetn), .target(target),
        .ramp(ramp), .volts(volts), .valid(valid));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Expected switch/status levels: doubler, bypass, enable, good_n
    task automatic outs(input logic [3:0] e);
        chk({28'h0, doubler_on, bypass_on, conv_en, bus_good_flag_n}, {28'h0, e});
    endtask

    // Request held until the rising edge that samples pready high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    // Counts edges until the chosen output reaches val
    task automatic wait_for(input int sel, input logic val);
        logic s;
        n = 0;
        do
        begin
            @(posedge pclk);
            #1;
            n++;
            s = (sel == 0) ? bypass_on : (sel == 1) ? conv_en :
                (sel == 2) ? bus_good_flag_n : doubler_on;
        end while (s !== val && n < 3000);
        if (n >= 3000)
        begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    task automatic go(input logic [9:0] t, input int cyc);
        @(posedge pclk);
        target <= t;
        repeat (cyc) @(posedge pclk);
        #1;
    endtask

    task automatic power_up();
        wait_for(0, 1'b1);
        wait_for(1, 1'b1);
        chk(n, DLY);
        wait_for(2, 1'b0);
        chk(n, DLY);
    endtask

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, ramp} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        target = 10'h000;
        num_errors = 0;
        total_checks = 0;
        void'($urandom(49));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        outs(4'h1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h5);
        v = 10'($urandom % 30 + 3);
        apb(1'b1, 8'h00, {22'($urandom), v});
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, {22'h0, v});
        apb(1'b1, 8'h04, 32'hFF);
        chk(err, 1'b1);
        apb(1'b0, 8'h0C + 8'($urandom % 60) * 8'h04, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        $display("test 1 done");
        // Steady high-line bus, full power-up
        v = 10'($urandom % 140 + 250);
        go(v, 0);
        power_up();
        outs(4'h6);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[7:0], 8'h64);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, {22'h0, v});
        $display("test 2 done");
        // Short sag above the disable level rides through
        go(10'h0CD, 40);
        outs(4'h7);
        go(10'h12C, 40);
        outs(4'h6);
        $display("test 3 done");
        // Collapse below disable level, then low-line restart
        go(10'h0B9, 0);
        wait_for(1, 1'b0);
        outs(4'h1);
        wait_for(3, 1'b1);
        outs(4'h9);
        go(10'h12C, 0);
        power_up();
        outs(4'hE);
        $display("test 4 done");
        // Overvoltage, recovery, then a fault collapse mid-delay
        go(10'h1A4, 0);
        wait_for(1, 1'b0);
        chk({bypass_on, conv_en, bus_good_flag_n}, 3'h1);
        go(10'h12C, 0);
        wait_for(0, 1'b1);
        go(10'h0AA, 0);
        wait_for(0, 1'b0);
        chk({conv_en, bus_good_flag_n}, 2'h1);
        $display("test 5 done");
        // Reset after the fault collapse, then a slow ramp must not look flat
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        outs(4'h1);
        apb(1'b1, 8'h00, 32'h2);
        ramp <= 1'b1;
        go(10'h12C, 0);
        wait_for(0, 1'b1);
        chk(doubler_on, 1'b0);
        $display("test 6 done");
        tally_and_finish();
    end
endmodule // tb_autoranging_rectifier_sequencer
`default_nettype wire
